// >>> rtl/ips_pkg.sv
// Shared constants and types for the phase control sequencer.
package ips_pkg;

    // Clock period of the single design clock.
    localparam int CLK_PERIOD_NS = 25;

    // Delay-line tap delays and the width of each tap pulse.
    localparam int TAP0_NS = 0;
    localparam int TAP50_NS = 50;
    localparam int TAP80_NS = 80;
    localparam int TAP100_NS = 100;
    localparam int TAP180_NS = 180;
    localparam int TAP300_NS = 300;
    localparam int PULSE_NS = 80;

    // Cycle counts: a tap is a least delay, so it rounds up.
    localparam int TAP0_CYC = (TAP0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP50_CYC = (TAP50_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP80_CYC = (TAP80_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP100_CYC = (TAP100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP180_CYC = (TAP180_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP300_CYC = (TAP300_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEQ_DONE_CYC = TAP300_CYC + PULSE_CYC;
    localparam int CNT_W = 5;

    // Tap indices within the tap vector.
    localparam int TAP_COUNT = 6;
    localparam int TI_0 = 0;
    localparam int TI_50 = 1;
    localparam int TI_80 = 2;
    localparam int TI_100 = 3;
    localparam int TI_180 = 4;
    localparam int TI_300 = 5;

    // Order register and data line layout.
    localparam int DATA_W = 8;
    localparam int ORDER_W = 5;
    localparam int ORDER_LSB = 3;

    // Positions of the single-bit pins in the synchronised pin vector.
    localparam int IN_FS = 0;
    localparam int IN_TIO = 1;
    localparam int IN_TDV = 2;
    localparam int IN_SIO = 3;
    localparam int IN_HIO = 4;
    localparam int IN_AIO = 5;
    localparam int IN_ASC = 6;
    localparam int IN_ADDR = 7;
    localparam int IN_INTP = 8;
    localparam int IN_DVT = 9;
    localparam int IN_REQUEST_STROBE_ACK = 10;
    localparam int IN_ES = 11;
    localparam int IN_UNE = 12;
    localparam int IN_CCH = 13;
    localparam int IN_ORDIN = 14;
    localparam int IN_ONLINE = 15;
    localparam int IN_HRST = 16;
    localparam int IN_BITS = 17;

    // Reset values of the control state.
    localparam logic LATCH_RST = 1'b1;
    localparam logic FLAG_RST = 1'b0;

    // Sequencer phases, one at a time.
    typedef enum logic [2:0] {
        PH_INIT, PH_WAIT, PH_LATE, PH_RACK, PH_RSTB, PH_TERM
    } ips_phase_type;

endpackage

// >>> rtl/ips_sync.sv
// Two-flop synchroniser for a vector of independent level pins.
module ips_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Only the second stage is visible; the first may be metastable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule

// >>> rtl/ips_tap_timer.sv
// Cycle-counter model of the self-timed delay line and its taps.
module ips_tap_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic [ips_pkg::TAP_COUNT-1:0] taps,
    output logic phaseClk,
    output logic running
);

    localparam int TAP_CYC [ips_pkg::TAP_COUNT] = '{ips_pkg::TAP0_CYC,
        ips_pkg::TAP50_CYC, ips_pkg::TAP80_CYC, ips_pkg::TAP100_CYC,
        ips_pkg::TAP180_CYC, ips_pkg::TAP300_CYC};

    logic [ips_pkg::CNT_W-1:0] cnt_q;
    logic [ips_pkg::CNT_W-1:0] cnt_d;
    logic run_q;
    logic run_d;

    // The counter stands for the delay line: count zero is the start.
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        if (start) begin
            cnt_d = '0;
            run_d = 1'b1;
        end else if (run_q) begin
            cnt_d = cnt_q + ips_pkg::CNT_W'(1);
            if (cnt_q == ips_pkg::CNT_W'(ips_pkg::SEQ_DONE_CYC - 1)) begin
                run_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            run_q <= ips_pkg::FLAG_RST;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end

    // Each tap is a pulse one pulse-width long at its fixed delay.
    for (genvar i = 0; i < ips_pkg::TAP_COUNT; i++) begin : g_tap
        assign taps[i] = run_q && (cnt_q >= ips_pkg::CNT_W'(TAP_CYC[i]))
            && (cnt_q < ips_pkg::CNT_W'(TAP_CYC[i] + ips_pkg::PULSE_CYC));
    end

    // Phase clock marks the falling edge of the 100 ns tap.
    assign phaseClk = run_q
        && (cnt_q == ips_pkg::CNT_W'(ips_pkg::TAP100_CYC + ips_pkg::PULSE_CYC));
    assign running = run_q;

    property p_tap100_after_start;
        @(posedge clk) disable iff (!rst_n)
        start |=> ##4 (taps[3] && !taps[5]) ##4 phaseClk;
    endproperty
    a_tap100_after_start: assert property (p_tap100_after_start)
        else $error("Tap 100 or its falling edge came at the wrong cycle.");

endmodule

// >>> rtl/ips_phase_sequencer.sv
// Phase control sequencer answering processor commands and service cycles.
// What this block does
// - Cycle latch sets on final tap so cycle-continue stays asserted online.
// - A new delay cycle starts when the delay line is idle and cycle-continue and the current phase's start gate hold.
// - Cycle latch clears at the 50 ns tap; start pulse lasts 80 ns.
// - Taps give 80 ns pulses at 0, 50, 80, 100, 180 and 300 ns.
// - Phases change only on the falling edge of the 100 ns tap or on host reset.
// - Busy clear forces request-ack, request-strobe and terminate phases off.
// - Host reset returns to the initial phase and clears busy.
// - Reset gives the initial phase; exactly one phase is active.
// - Initial phase starts on strobe with addressed command or interrupt acknowledge.
// - Operational flag clears at the 80 ns tap of the initial phase.
// - Initial moves to strobe-wait, which restarts the delay line once the current run ends.
// - Strobe-wait loads operational flag from device test line for test, test-device, halt and start commands.
// - Strobe-late drives responses and restarts when the function strobe drops.
// - Without service connect, strobe-late returns to the initial phase.
// - Busy sets at 80 ns in strobe-late for an acceptable start command.
// - Busy in the initial phase directly sets the service call flag.
// - Busy clears only in terminate-order of an order-in cycle, or host reset.
// - Strobe with addressed service call acknowledge starts the order-out cycle.
// - Service connect sets as strobe falls; request-ack then raises request strobe.
// - Service connect clears on end service as request strobe falls.
// - Request acknowledge drops strobe, restarts and stores the order code.
// - Request-strobe phase raises strobe again once acknowledge is removed.
// - Request-strobe leads to terminate-order, then back to the initial phase.
module ips_phase_sequencer (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic functionStrobeIn,
    input wire logic testIoCommand,
    input wire logic testDeviceCommand,
    input wire logic startIoCommand,
    input wire logic haltIoCommand,
    input wire logic acknowledgeInterruptCommand,
    input wire logic serviceCallAcknowledge,
    input wire logic controllerAddressed,
    input wire logic interruptPendingFlag,
    input wire logic deviceTestLine,
    input wire logic requestStrobeAck,
    input wire logic endService,
    input wire logic unusualEnd,
    input wire logic commandChain,
    input wire logic orderInCycle,
    input wire logic onlineMode,
    input wire logic hostReset,
    input wire logic [ips_pkg::DATA_W-1:0] dataLines,
    output logic phaseInitialN,
    output logic phaseStrobeWait,
    output logic phaseStrobeLate,
    output logic phaseRequestAck,
    output logic phaseRequestStrobe,
    output logic phaseTerminateOrder,
    output logic controllerBusyFlag,
    output logic deviceOperationalFlag,
    output logic serviceCallFlag,
    output logic serviceConnectFlag,
    output logic requestStrobeOut,
    output logic functionResponseEn,
    output logic [1:0] condCode,
    output logic [ips_pkg::ORDER_W-1:0] orderCode
);

    logic [1:0] rstPipe_q;
    logic rst_n;
    logic [ips_pkg::IN_BITS-1:0] pinRaw;
    logic [ips_pkg::IN_BITS-1:0] pinS;
    logic [ips_pkg::DATA_W-1:0] dataS;
    logic fs, ttCmd, ascCmd, aioOk, request_strobe_ack, endSvc, hostRst;
    logic [ips_pkg::TAP_COUNT-1:0] taps;
    logic phaseClk, running, tap80Start, tap80Prev_q;
    logic cycleContinue, startGate, startNow, fsPrev_q, fsFall;
    ips_pkg::ips_phase_type state_q, state_d;
    logic cycleLatch_q, cycleLatch_d;
    logic cmdTt_q, cmdTt_d, cmdSio_q, cmdSio_d, cmdAsc_q, cmdAsc_d;
    logic busy_q, busy_d, device_operational_flag_q, device_operational_flag_d, scall_q, scall_d;
    logic fsc_q, fsc_d, rsd_q, rsd_d, respEn_q, respEn_d;
    logic [1:0] cc_q, cc_d;
    logic [ips_pkg::ORDER_W-1:0] order_q, order_d;
    logic [5:0] phaseVec_q, phaseVec_d;
    logic initN_q;

    // The reset pin is released through two flops so all flops leave reset together.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rst_n = rstPipe_q[1];

    // Every processor line is asynchronous to clk and is synchronised first.
    assign pinRaw = {hostReset, onlineMode, orderInCycle, commandChain, unusualEnd,
        endService, requestStrobeAck, deviceTestLine, interruptPendingFlag,
        controllerAddressed, serviceCallAcknowledge, acknowledgeInterruptCommand,
        haltIoCommand, startIoCommand, testDeviceCommand, testIoCommand,
        functionStrobeIn};

    ips_sync #(.W(ips_pkg::IN_BITS)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(pinRaw),
        .dout(pinS)
    );

    // Data lines only matter while the processor holds them with its acknowledge.
    ips_sync #(.W(ips_pkg::DATA_W)) u_data_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(dataLines),
        .dout(dataS)
    );

    ips_tap_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(startNow),
        .taps(taps),
        .phaseClk(phaseClk),
        .running(running)
    );

    // Decoded command and handshake conditions.
    assign fs = pinS[ips_pkg::IN_FS];
    assign ttCmd = pinS[ips_pkg::IN_ADDR] && (pinS[ips_pkg::IN_TIO]
        || pinS[ips_pkg::IN_TDV] || pinS[ips_pkg::IN_SIO] || pinS[ips_pkg::IN_HIO]);
    assign ascCmd = pinS[ips_pkg::IN_ADDR] && pinS[ips_pkg::IN_ASC];
    assign aioOk = pinS[ips_pkg::IN_AIO] && pinS[ips_pkg::IN_INTP];
    assign request_strobe_ack = pinS[ips_pkg::IN_REQUEST_STROBE_ACK];
    assign endSvc = pinS[ips_pkg::IN_ES];
    assign hostRst = pinS[ips_pkg::IN_HRST];
    assign fsFall = fsPrev_q && !fs;
    assign tap80Start = taps[ips_pkg::TI_80] && !tap80Prev_q;

    // Cycle-continue gates every start; the latch blocks restarts mid-cycle.
    assign cycleContinue = cycleLatch_q && pinS[ips_pkg::IN_ONLINE];

    // One start gate per phase; the phase picks which gate can fire.
    always_comb begin
        case (state_q)
            ips_pkg::PH_INIT: startGate = fs && (ttCmd || aioOk || ascCmd);
            ips_pkg::PH_WAIT: startGate = 1'b1;
            ips_pkg::PH_LATE: startGate = !fs;
            ips_pkg::PH_RACK: startGate = request_strobe_ack;
            ips_pkg::PH_RSTB: startGate = !request_strobe_ack;
            ips_pkg::PH_TERM: startGate = request_strobe_ack || endSvc;
            default: startGate = 1'b0;
        endcase
    end
    assign startNow = cycleContinue && startGate && !running;

    // Cycle latch: set by the final tap, cleared by the 50 ns tap.
    always_comb begin
        cycleLatch_d = cycleLatch_q;
        if (taps[ips_pkg::TI_50]) begin
            cycleLatch_d = 1'b0;
        end else if (taps[ips_pkg::TI_300]) begin
            cycleLatch_d = 1'b1;
        end
    end

    // Phase sequence; forced returns to the initial phase override the step.
    always_comb begin
        state_d = state_q;
        if (phaseClk) begin
            case (state_q)
                ips_pkg::PH_INIT: state_d = ips_pkg::PH_WAIT;
                ips_pkg::PH_WAIT: state_d = ips_pkg::PH_LATE;
                ips_pkg::PH_LATE: state_d = fsc_q ? ips_pkg::PH_RACK : ips_pkg::PH_INIT;
                ips_pkg::PH_RACK: state_d = ips_pkg::PH_RSTB;
                ips_pkg::PH_RSTB: state_d = ips_pkg::PH_TERM;
                ips_pkg::PH_TERM: state_d = ips_pkg::PH_INIT;
                default: state_d = ips_pkg::PH_INIT;
            endcase
        end
        if (!busy_q && (state_d == ips_pkg::PH_RACK || state_d == ips_pkg::PH_RSTB
            || state_d == ips_pkg::PH_TERM)) begin
            state_d = ips_pkg::PH_INIT;
        end
        if (hostRst) begin
            state_d = ips_pkg::PH_INIT;
        end
        phaseVec_d = 6'h00;
        phaseVec_d[state_d] = 1'b1;
    end

    // Command kind is captured when the initial phase starts, since the
    // processor may change the indicator lines once the strobe falls.
    always_comb begin
        cmdTt_d = cmdTt_q;
        cmdSio_d = cmdSio_q;
        cmdAsc_d = cmdAsc_q;
        if (startNow && state_q == ips_pkg::PH_INIT) begin
            cmdTt_d = ttCmd;
            cmdSio_d = ttCmd && pinS[ips_pkg::IN_SIO];
            cmdAsc_d = ascCmd;
        end
    end

    // Operational flag: cleared then resampled from the selection unit.
    always_comb begin
        device_operational_flag_d = device_operational_flag_q;
        if (tap80Start && state_q == ips_pkg::PH_INIT) begin
            device_operational_flag_d = 1'b0;
        end else if (tap80Start && state_q == ips_pkg::PH_WAIT && cmdTt_q) begin
            device_operational_flag_d = pinS[ips_pkg::IN_DVT];
        end
    end

    // Busy: accepted start sets it; only an order-in terminate or host reset clears.
    always_comb begin
        busy_d = busy_q;
        if (state_q == ips_pkg::PH_TERM && phaseClk && pinS[ips_pkg::IN_ORDIN]
            && (!pinS[ips_pkg::IN_CCH] || endSvc || pinS[ips_pkg::IN_UNE])) begin
            busy_d = 1'b0;
        end
        if (state_q == ips_pkg::PH_LATE && tap80Start && cmdSio_q && !busy_q
            && !pinS[ips_pkg::IN_INTP] && device_operational_flag_q) begin
            busy_d = 1'b1;
        end
        if (hostRst) begin
            busy_d = 1'b0;
        end
    end

    // Service call flag is direct set while busy waits in the initial phase.
    always_comb begin
        scall_d = scall_q;
        if (startNow && state_q == ips_pkg::PH_INIT && ascCmd) begin
            scall_d = 1'b0;
        end
        if (busy_q && state_q == ips_pkg::PH_INIT && cycleContinue && !scall_q
            && !pinS[ips_pkg::IN_UNE] && !hostRst) begin
            scall_d = 1'b1;
        end
    end

    // Service connect and request strobe form the order-out handshake.
    always_comb begin
        fsc_d = fsc_q;
        rsd_d = rsd_q;
        if (fsc_q && endSvc && rsd_q && request_strobe_ack) begin
            fsc_d = 1'b0;
        end
        if (state_q == ips_pkg::PH_LATE && cmdAsc_q && fsFall) begin
            fsc_d = 1'b1;
        end
        if (hostRst) begin
            fsc_d = 1'b0;
        end
        if (!fsc_q || request_strobe_ack) begin
            rsd_d = 1'b0;
        end else if (phaseClk && state_q == ips_pkg::PH_LATE) begin
            rsd_d = 1'b1;
        end else if (startNow && state_q == ips_pkg::PH_RSTB) begin
            rsd_d = 1'b1;
        end
    end

    // Order register loads as the acknowledge restarts the request-ack phase.
    always_comb begin
        order_d = order_q;
        if (startNow && state_q == ips_pkg::PH_RACK) begin
            order_d = dataS[ips_pkg::ORDER_LSB +: ips_pkg::ORDER_W];
        end
    end

    // Response enable and condition code only stand during strobe-late.
    // An accepted start keeps its code after it sets busy; an older busy refuses it.
    always_comb begin
        respEn_d = (state_d == ips_pkg::PH_LATE);
        cc_d = 2'h0;
        if (respEn_d) begin
            cc_d[1] = device_operational_flag_q && cmdSio_q && !pinS[ips_pkg::IN_INTP]
                && (!busy_q || cc_q[1]);
            cc_d[0] = device_operational_flag_q;
        end
    end

    // All sequencer state registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ips_pkg::PH_INIT;
            phaseVec_q <= 6'h01;
            initN_q <= ips_pkg::FLAG_RST;
            cycleLatch_q <= ips_pkg::LATCH_RST;
            cmdTt_q <= ips_pkg::FLAG_RST;
            cmdSio_q <= ips_pkg::FLAG_RST;
            cmdAsc_q <= ips_pkg::FLAG_RST;
            device_operational_flag_q <= ips_pkg::FLAG_RST;
            busy_q <= ips_pkg::FLAG_RST;
            scall_q <= ips_pkg::FLAG_RST;
            fsc_q <= ips_pkg::FLAG_RST;
            rsd_q <= ips_pkg::FLAG_RST;
            respEn_q <= ips_pkg::FLAG_RST;
            cc_q <= 2'h0;
            order_q <= '0;
            fsPrev_q <= ips_pkg::FLAG_RST;
            tap80Prev_q <= ips_pkg::FLAG_RST;
        end else begin
            state_q <= state_d;
            phaseVec_q <= phaseVec_d;
            initN_q <= !phaseVec_d[0];
            cycleLatch_q <= cycleLatch_d;
            cmdTt_q <= cmdTt_d;
            cmdSio_q <= cmdSio_d;
            cmdAsc_q <= cmdAsc_d;
            device_operational_flag_q <= device_operational_flag_d;
            busy_q <= busy_d;
            scall_q <= scall_d;
            fsc_q <= fsc_d;
            rsd_q <= rsd_d;
            respEn_q <= respEn_d;
            cc_q <= cc_d;
            order_q <= order_d;
            fsPrev_q <= fs;
            tap80Prev_q <= taps[ips_pkg::TI_80];
        end
    end

    // Outputs straight from flops.
    assign phaseInitialN = initN_q; // Own flop, so the active-low pin has no gate.
    assign phaseStrobeWait = phaseVec_q[1];
    assign phaseStrobeLate = phaseVec_q[2];
    assign phaseRequestAck = phaseVec_q[3];
    assign phaseRequestStrobe = phaseVec_q[4];
    assign phaseTerminateOrder = phaseVec_q[5];
    assign controllerBusyFlag = busy_q;
    assign deviceOperationalFlag = device_operational_flag_q;
    assign serviceCallFlag = scall_q;
    assign serviceConnectFlag = fsc_q;
    assign requestStrobeOut = rsd_q;
    assign functionResponseEn = respEn_q;
    assign condCode = cc_q;
    assign orderCode = order_q;

    property p_latch_set;
        @(posedge clk) disable iff (!rst_n)
        (taps[5] && !taps[1]) |=> cycleLatch_q;
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("Cycle latch not set by the final tap.");

    property p_latch_clear;
        @(posedge clk) disable iff (!rst_n)
        $rose(taps[1]) |=> !cycleLatch_q [*4];
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("Cycle latch not held clear from the 50 ns tap.");

    property p_one_phase;
        @(posedge clk) disable iff (!rst_n)
        $onehot(phaseVec_q);
    endproperty
    a_one_phase: assert property (p_one_phase)
        else $error("More or fewer than one phase active.");

    property p_phase_stable;
        @(posedge clk) disable iff (!rst_n)
        (!phaseClk && !hostRst) |=> $stable(state_q);
    endproperty
    a_phase_stable: assert property (p_phase_stable)
        else $error("Phase changed away from the 100 ns tap falling edge.");

    property p_busy_hold;
        @(posedge clk) disable iff (!rst_n)
        !busy_q |=> (phaseVec_q[5:3] == 3'h0);
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("Order phase active while busy is clear.");

    property p_wait_restart;
        @(posedge clk) disable iff (!rst_n)
        ($rose(phaseVec_q[1]) && pinS[ips_pkg::IN_ONLINE] && !hostRst)
            |-> ##[1:12] startNow;
    endproperty
    a_wait_restart: assert property (p_wait_restart)
        else $error("Strobe-wait did not restart the delay line in time.");

    property p_busy_set;
        @(posedge clk) disable iff (!rst_n)
        $rose(busy_q) |-> ($past(state_q) == ips_pkg::PH_LATE && $past(cmdSio_q)
            && $past(device_operational_flag_q));
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("Busy set outside an accepted start in strobe-late.");

    property p_busy_clear;
        @(posedge clk) disable iff (!rst_n)
        $fell(busy_q) |-> ($past(hostRst)
            || ($past(state_q) == ips_pkg::PH_TERM && $past(phaseClk)));
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("Busy cleared outside terminate-order or host reset.");

    property p_ack_drops_strobe;
        @(posedge clk) disable iff (!rst_n)
        request_strobe_ack |=> !rsd_q;
    endproperty
    a_ack_drops_strobe: assert property (p_ack_drops_strobe)
        else $error("Request strobe stayed up under acknowledge.");

    property p_fsc_hold;
        @(posedge clk) disable iff (!rst_n)
        $fell(fsc_q) |-> ($past(hostRst)
            || ($past(endSvc) && $past(request_strobe_ack) && $past(rsd_q)));
    endproperty
    a_fsc_hold: assert property (p_fsc_hold)
        else $error("Service connect cleared without end service.");

    property p_order_load;
        @(posedge clk) disable iff (!rst_n)
        (startNow && state_q == ips_pkg::PH_RACK)
            |=> (order_q == $past(dataS[7:3]));
    endproperty
    a_order_load: assert property (p_order_load)
        else $error("Order code not stored from the data lines.");

endmodule

// >>> tb/ips_iop_model.sv
// Channel model that answers the device's request strobe, promptly or after a wait.
module ips_iop_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic requestStrobeOut,
    input wire logic [3:0] ackDelay,
    output logic requestStrobeAck
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] waitCnt;
    // Acknowledge is held until the strobe falls, so the device sees a full handshake.
    always @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            requestStrobeAck <= 1'b0;
            waitCnt <= 4'h0;
        end else if (!requestStrobeOut) begin
            requestStrobeAck <= 1'b0;
            waitCnt <= 4'h0;
        end else if (waitCnt >= ackDelay) begin
            requestStrobeAck <= 1'b1;
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule

// >>> tb/ips_phase_sequencer_tb_top.sv
// Self-checking bench for the phase control sequencer.
module ips_phase_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, arst_n, functionStrobeIn, testIoCommand, testDeviceCommand, startIoCommand;
    logic haltIoCommand, acknowledgeInterruptCommand, serviceCallAcknowledge;
    logic controllerAddressed, interruptPendingFlag, deviceTestLine, requestStrobeAck;
    logic endService, unusualEnd, commandChain, orderInCycle, onlineMode, hostReset;
    logic [ips_pkg::DATA_W-1:0] dataLines;
    logic phaseInitialN, phaseStrobeWait, phaseStrobeLate, phaseRequestAck;
    logic phaseRequestStrobe, phaseTerminateOrder, controllerBusyFlag, deviceOperationalFlag;
    logic serviceCallFlag, serviceConnectFlag, requestStrobeOut, functionResponseEn;
    logic [1:0] condCode;
    logic [ips_pkg::ORDER_W-1:0] orderCode;
    logic [3:0] ackDelay;
    int failures = 0;
    int nCompared = 0;
    int cycles = 0;
    ips_phase_sequencer dut_u (.*);
    ips_iop_model iop_u (.*);
    // Clock at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // A hang is cut short well after the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            results();
        end
    end
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Kind picks one of test, test-device, halt, start, interrupt ack, service call ack.
    task automatic command(int kind, logic [1:0] ccMask, logic [1:0] ccExp);
        {testIoCommand, testDeviceCommand, haltIoCommand, startIoCommand,
            acknowledgeInterruptCommand, serviceCallAcknowledge} = 6'h20 >> kind;
        functionStrobeIn = 1'b1;
        for (int i = 0; i < 60 && phaseStrobeLate !== 1'b1; i++) @(negedge clk);
        check({phaseStrobeLate, functionResponseEn}, 2'h3);
        check(condCode & ccMask, ccExp);
        functionStrobeIn = 1'b0;
        for (int i = 0; i < 40 && phaseInitialN !== 1'b0 && !phaseRequestAck; i++)
            @(negedge clk);
        {testIoCommand, testDeviceCommand, haltIoCommand, startIoCommand} = 4'h0;
        acknowledgeInterruptCommand = 1'b0;
        check({functionResponseEn, condCode}, 3'h0);
    endtask
    task automatic test_refused;
        onlineMode = 1'b0;
        testIoCommand = 1'b1;
        functionStrobeIn = 1'b1;
        repeat (40) @(negedge clk);
        check(phaseStrobeWait, 1'b0);
        {onlineMode, controllerAddressed} = 2'b10;
        repeat (40) @(negedge clk);
        check(phaseStrobeWait, 1'b0);
        {functionStrobeIn, testIoCommand, controllerAddressed} = 3'b001;
        repeat (40) @(negedge clk);
        $display("test refused done");
    endtask
    task automatic test_commands;
        for (int k = 0; k < 5; k++) begin
            deviceTestLine = k[0];
            interruptPendingFlag = (k == 4);
            command(k, (k == 4) ? 2'b00 : {k == 3, 1'b1}, {k == 3, (k != 4) & k[0]});
            check(phaseInitialN, 1'b0);
            check(deviceOperationalFlag, (k != 4) & k[0]);
            check(controllerBusyFlag, (k >= 3));
        end
        interruptPendingFlag = 1'b0;
        $display("test commands done");
    endtask
    task automatic test_start;
        deviceTestLine = 1'b1;
        command(3, 2'b10, 2'b00);
        for (int i = 0; i < 20 && serviceCallFlag !== 1'b1; i++) @(negedge clk);
        check(serviceCallFlag, 1'b1);
        $display("test start done");
    endtask
    task automatic test_order_out;
        dataLines = 8'hA8;
        ackDelay = 4'h6;
        command(5, 2'b00, 2'b00);
        check(phaseRequestAck, 1'b1);
        check({serviceConnectFlag, requestStrobeOut}, 2'h3);
        for (int i = 0; i < 60 && phaseRequestStrobe !== 1'b1; i++) @(negedge clk);
        check({phaseRequestStrobe, orderCode}, 6'h35);
        endService = 1'b1;
        for (int i = 0; i < 60 && phaseTerminateOrder !== 1'b1; i++) @(negedge clk);
        check(phaseTerminateOrder, 1'b1);
        for (int i = 0; i < 60 && phaseInitialN !== 1'b0; i++) @(negedge clk);
        check({phaseInitialN, serviceConnectFlag}, 2'h0);
        check(controllerBusyFlag, 1'b1);
        {endService, serviceCallAcknowledge} = 2'b00;
        $display("test order out done");
    endtask
    task automatic test_host_reset;
        hostReset = 1'b1;
        @(negedge clk);
        hostReset = 1'b0;
        repeat (5) @(negedge clk);
        check({controllerBusyFlag, phaseInitialN}, 2'h0);
        $display("test host reset done");
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Reset for 16 cycles, then the scenarios in order.
    initial begin
        {arst_n, functionStrobeIn, testIoCommand, testDeviceCommand, startIoCommand} = '0;
        {haltIoCommand, acknowledgeInterruptCommand, serviceCallAcknowledge} = '0;
        {interruptPendingFlag, deviceTestLine, endService, unusualEnd} = '0;
        {commandChain, orderInCycle, hostReset, dataLines} = '0;
        {onlineMode, controllerAddressed, ackDelay} = 6'h31;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (5) @(negedge clk);
        check({phaseInitialN, phaseStrobeWait, phaseStrobeLate, phaseRequestAck}, 4'h0);
        check({phaseRequestStrobe, phaseTerminateOrder, controllerBusyFlag}, 3'h0);
        test_refused();
        test_commands();
        test_start();
        test_order_out();
        test_host_reset();
        results();
    end
endmodule
